//--- hw/sledg_consts.vh
`ifndef SLEDG_CONSTS_VH
`define SLEDG_CONSTS_VH

// ============================================================
// mode encodings of a general indicator
`define SLEDG_MODE_W 2
`define SLEDG_MODE_SOLUTION 2'h0
`define SLEDG_MODE_KINEMATIC 2'h1
`define SLEDG_MODE_CORRECTION 2'h2
`define SLEDG_MODE_TRACKING 2'h3

// ============================================================
// kinematic state encodings
`define SLEDG_KIN_NONE 2'h0
`define SLEDG_KIN_FLOAT 2'h1
`define SLEDG_KIN_FIXED 2'h2

// ============================================================
// timing, times in microseconds, clock in MHz
`define SLEDG_CLK_MHZ 25
`define SLEDG_FAST_HALF_US 50000
`define SLEDG_BLINK_ON_US 150000
`define SLEDG_BLINK_GAP_US 250000
`define SLEDG_PAUSE_US 1500000
`define SLEDG_FLOAT_HALF_US 250000
`define SLEDG_LOG_BLINK_US 50000
`define SLEDG_CYC(us) ((us) * `SLEDG_CLK_MHZ)
`define SLEDG_CNT_W 26
`define SLEDG_MAX_BURST 3'h5
`endif

//--- hw/sledg_burst.v
`include "sledg_consts.vh"
// ============================================================
// burst blinker: count of blinks then a long pause
module sledg_burst #(
  parameter [25:0] FAST_HALF = `SLEDG_CYC(`SLEDG_FAST_HALF_US),
  parameter [25:0] ON_CYC = `SLEDG_CYC(`SLEDG_BLINK_ON_US),
  parameter [25:0] GAP_CYC = `SLEDG_CYC(`SLEDG_BLINK_GAP_US),
  parameter [25:0] PAUSE_CYC = `SLEDG_CYC(`SLEDG_PAUSE_US)
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] blinkCount, // 0 means fast continuous blink
  output reg ledOut_ff
);
  localparam [1:0] ST_ON = 2'h0;
  localparam [1:0] ST_GAP = 2'h1;
  localparam [1:0] ST_PAUSE = 2'h2;
  localparam [1:0] ST_FAST = 2'h3;
  reg [1:0] state_ff; // current phase
  reg [1:0] nxt_state;
  reg [25:0] timer_ff; // cycles left in phase
  reg [25:0] nxt_timer;
  reg [2:0] done_ff; // blinks finished in burst
  reg [2:0] nxt_done;
  reg nxt_led;

  // ============================================================
  // phase sequencer; count is read live at the end of every phase
  always @* begin
    nxt_state = state_ff;
    nxt_timer = timer_ff - 26'h1;
    nxt_done = done_ff;
    nxt_led = ledOut_ff;
    if (timer_ff == 26'h0) begin
      case (state_ff)
        ST_ON: begin
          nxt_done = done_ff + 3'h1;
          nxt_led = 1'b0;
          // pause well above gap keeps counts readable
          if (done_ff + 3'h1 >= blinkCount) begin
            nxt_state = ST_PAUSE;
            nxt_timer = PAUSE_CYC - 26'h1;
          end else begin
            nxt_state = ST_GAP;
            nxt_timer = GAP_CYC - 26'h1;
          end
        end
        ST_GAP, ST_PAUSE, ST_FAST: begin
          if (blinkCount == 3'h0) begin
            // zero: ten blinks per second
            nxt_state = ST_FAST;
            nxt_led = ~ledOut_ff;
            nxt_timer = FAST_HALF - 26'h1;
            nxt_done = 3'h0;
          end else begin
            nxt_state = ST_ON;
            nxt_led = 1'b1;
            nxt_timer = ON_CYC - 26'h1;
            if (state_ff != ST_GAP) nxt_done = 3'h0;
          end
        end
        default: begin
          nxt_state = ST_PAUSE;
          nxt_timer = 26'h0;
        end
      endcase
    end
  end

  // ============================================================
  // phase registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_PAUSE;
      timer_ff <= 26'h0;
      done_ff <= 3'h0;
      ledOut_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      done_ff <= nxt_done;
      ledOut_ff <= nxt_led;
    end
  end
endmodule // sledg_burst

//--- hw/sledg_status_led.v
`include "sledg_consts.vh"
// ============================================================
// status indicator pattern generator
module sledg_status_led (
  input wire ref_clk,
  input wire rst_n,
  input wire modeWrite, // one-cycle strobe of mode command
  input wire modeSelect, // 0 general indicator one, 1 two
  input wire [1:0] modeValue, // new mode
  input wire solutionValid, // position solution available
  input wire [1:0] kinematicState, // none, float, fixed
  input wire baseStation, // static base sending corrections
  input wire correctionSeen, // any correction message received
  input wire [7:0] correctedSats, // satellites with corrections
  input wire [7:0] trackedSats, // satellites in tracking
  input wire cardMounted, // card present and mounted
  input wire logActivity, // one-cycle pulse per logging event
  output reg generalIndicatorOne_ff,
  output reg generalIndicatorTwo_ff,
  output reg loggingIndicator_ff,
  output reg [1:0] modeOne_ff,
  output reg [1:0] modeTwo_ff
);
  localparam [25:0] FLOAT_HALF = `SLEDG_CYC(`SLEDG_FLOAT_HALF_US);
  localparam [25:0] LOG_BLINK = `SLEDG_CYC(`SLEDG_LOG_BLINK_US);
  localparam [25:0] LOG_DARK = LOG_BLINK + LOG_BLINK;

  // ============================================================
  // count to burst length: 1-2 one, 3-4 two ... 9+ five
  function [2:0] burstOf;
    input [7:0] sats;
    begin
      if (sats == 8'h0) burstOf = 3'h0;
      else if (sats >= 8'h9) burstOf = `SLEDG_MAX_BURST;
      else burstOf = sats[3:1] + {2'h0, sats[0]};
    end
  endfunction

  wire [2:0] corrCount = burstOf(correctedSats);
  wire [2:0] trackCount = burstOf(trackedSats);
  wire corrBlink;
  wire trackBlink;

  // ============================================================
  // shared burst blinkers, one per count source
  sledg_burst uCorr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .blinkCount(corrCount),
    .ledOut_ff(corrBlink)
  );
  sledg_burst uTrack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .blinkCount(trackCount),
    .ledOut_ff(trackBlink)
  );

  // ============================================================
  // float blink square wave
  reg [25:0] floatCnt_ff;
  reg floatWave_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      floatCnt_ff <= 26'h0;
      floatWave_ff <= 1'b0;
    end else if (floatCnt_ff == 26'h0) begin
      floatCnt_ff <= FLOAT_HALF - 26'h1;
      floatWave_ff <= ~floatWave_ff;
    end else begin
      floatCnt_ff <= floatCnt_ff - 26'h1;
    end
  end

  // ============================================================
  // mode registers, written by the mode command
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeOne_ff <= `SLEDG_MODE_SOLUTION;
      modeTwo_ff <= `SLEDG_MODE_KINEMATIC;
    end else if (modeWrite) begin
      if (modeSelect) modeTwo_ff <= modeValue;
      else modeOne_ff <= modeValue;
    end
  end

  // ============================================================
  // per-mode level for a general indicator
  function levelOf;
    input [1:0] mode;
    input wave;
    input [1:0] kin;
    input base;
    input seen;
    input corrB;
    input trackB;
    begin
      case (mode)
        `SLEDG_MODE_SOLUTION: levelOf = solutionValid;
        `SLEDG_MODE_KINEMATIC: begin
          if (kin == `SLEDG_KIN_FIXED) levelOf = 1'b1;
          else if (kin == `SLEDG_KIN_FLOAT) levelOf = wave;
          else levelOf = 1'b0;
        end
        `SLEDG_MODE_CORRECTION: begin
          if (base) levelOf = 1'b1;
          else if (!seen) levelOf = 1'b0;
          else levelOf = corrB;
        end
        `SLEDG_MODE_TRACKING: levelOf = trackB;
        default: levelOf = 1'b0;
      endcase
    end
  endfunction

  // ============================================================
  // logging blink: dark for a short time after activity
  reg [25:0] logCnt_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      logCnt_ff <= 26'h0;
    end else if (!cardMounted) begin
      logCnt_ff <= 26'h0;
    end else if (logActivity && logCnt_ff == 26'h0) begin
      // activity during a blink is folded in, so blinks stay visible
      logCnt_ff <= LOG_DARK - 26'h1;
    end else if (logCnt_ff != 26'h0) begin
      logCnt_ff <= logCnt_ff - 26'h1;
    end
  end

  // ============================================================
  // output flops, high means lit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      generalIndicatorOne_ff <= 1'b0;
      generalIndicatorTwo_ff <= 1'b0;
      loggingIndicator_ff <= 1'b0;
    end else begin
      generalIndicatorOne_ff <= levelOf(modeOne_ff, floatWave_ff,
        kinematicState, baseStation, correctionSeen, corrBlink,
        trackBlink);
      generalIndicatorTwo_ff <= levelOf(modeTwo_ff, floatWave_ff,
        kinematicState, baseStation, correctionSeen, corrBlink,
        trackBlink);
      if (!cardMounted) loggingIndicator_ff <= 1'b0;
      else loggingIndicator_ff <= (logCnt_ff < LOG_BLINK);
    end
  end
endmodule // sledg_status_led

//--- dv/sledg_status_led_properties.sv
`include "sledg_consts.vh"
// ============================================================
// port checks of the status indicator generator
module sledg_status_led_properties (
  input wire ref_clk,
  input wire rst_n,
  input wire modeWrite,
  input wire modeSelect,
  input wire [1:0] modeValue,
  input wire solutionValid,
  input wire [1:0] kinematicState,
  input wire baseStation,
  input wire correctionSeen,
  input wire cardMounted,
  input wire logActivity,
  input wire generalIndicatorOne_ff,
  input wire generalIndicatorTwo_ff,
  input wire loggingIndicator_ff,
  input wire [1:0] modeOne_ff,
  input wire [1:0] modeTwo_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ============================================================
  // mode selection
  a_reset_modes: assert property ($rose(rst_n) |->
    $past(modeOne_ff) == `SLEDG_MODE_SOLUTION &&
    $past(modeTwo_ff) == `SLEDG_MODE_KINEMATIC) else $error("reset modes");
  a_write_one: assert property (modeWrite && !modeSelect |=>
    modeOne_ff == $past(modeValue) && $stable(modeTwo_ff))
    else $error("mode one write");
  a_write_two: assert property (modeWrite && modeSelect |=>
    modeTwo_ff == $past(modeValue) && $stable(modeOne_ff))
    else $error("mode two write");
  a_mode_hold: assert property (!modeWrite |=>
    $stable(modeOne_ff) && $stable(modeTwo_ff)) else $error("mode moved");
  // ============================================================
  // indicator levels; three steady cycles, two for the logging lamp, cover the pipeline depth
  a_sol_follow: assert property ((modeOne_ff == `SLEDG_MODE_SOLUTION &&
    $stable(solutionValid))[*3] |-> generalIndicatorOne_ff == solutionValid)
    else $error("solution level");
  a_kin_level: assert property ((modeTwo_ff == `SLEDG_MODE_KINEMATIC &&
    $stable(kinematicState) && kinematicState != `SLEDG_KIN_FLOAT)[*3] |->
    generalIndicatorTwo_ff == (kinematicState == `SLEDG_KIN_FIXED))
    else $error("kinematic level");
  a_base_solid: assert property ((modeOne_ff == `SLEDG_MODE_CORRECTION &&
    baseStation)[*3] |-> generalIndicatorOne_ff) else $error("base dark");
  a_no_corr_dark: assert property ((modeOne_ff == `SLEDG_MODE_CORRECTION &&
    !baseStation && !correctionSeen)[*3] |-> !generalIndicatorOne_ff)
    else $error("lit without corrections");
  a_log_dark: assert property ((!cardMounted)[*2] |->
    !loggingIndicator_ff) else $error("log lit unmounted");
  // main scenarios reached
  c_write_two: cover property (modeWrite && modeSelect);
  c_base: cover property (modeOne_ff == `SLEDG_MODE_CORRECTION && baseStation);
  c_log: cover property (cardMounted && logActivity);
endmodule // sledg_status_led_properties

bind sledg_status_led sledg_status_led_properties sledg_props_i (
  .ref_clk, .rst_n, .modeWrite, .modeSelect, .modeValue, .solutionValid,
  .kinematicState, .baseStation, .correctionSeen, .cardMounted,
  .logActivity, .generalIndicatorOne_ff, .generalIndicatorTwo_ff,
  .loggingIndicator_ff, .modeOne_ff, .modeTwo_ff);

//--- dv/sledg_led_model.sv
// ============================================================
// external lamps, lit while their pin is high
module sledg_led_model (
  input wire [2:0] ledPin, // log, two, one
  output logic [2:0] lit // lamp state as a viewer sees it
);
  timeunit 1ns;
  timeprecision 1ps;
  // lamps wired active high, no inversion on the board
  assign lit = ledPin;
endmodule // sledg_led_model

//--- dv/tb_top.sv
`include "sledg_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, modeWrite = 0, modeSelect = 0;
  logic solutionValid = 0, baseStation = 0, correctionSeen = 0;
  logic cardMounted = 0, logActivity = 0;
  logic [1:0] modeValue = 0, kinematicState = 0;
  logic [7:0] correctedSats = 0, trackedSats = 0;
  wire generalIndicatorOne_ff, generalIndicatorTwo_ff, loggingIndicator_ff;
  wire [1:0] modeOne_ff, modeTwo_ff;
  wire [2:0] lit; // lamps seen through the model
  logic [31:0] lfsrState = 32'hB034E0C8;
  logic [4:0] expQ[$]; // field select and expected value
  int nMismatch = 0, samplesChecked = 0, cycles = 0;
  event chk;
  sledg_status_led sledg_status_led_i (.ref_clk, .rst_n, .modeWrite,
    .modeSelect, .modeValue, .solutionValid, .kinematicState, .baseStation,
    .correctionSeen, .correctedSats, .trackedSats, .cardMounted,
    .logActivity, .generalIndicatorOne_ff, .generalIndicatorTwo_ff,
    .loggingIndicator_ff, .modeOne_ff, .modeTwo_ff);
  sledg_led_model sledg_led_model_i (.ledPin({loggingIndicator_ff,
    generalIndicatorTwo_ff, generalIndicatorOne_ff}), .lit(lit));
  initial forever #20 ref_clk = ~ref_clk;
  // ============================================================
  // helpers; inputs move only at falling edges
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // note an expectation; the delay keeps two events apart
  task automatic note(input logic [2:0] sel, input logic [1:0] val);
    expQ.push_back({sel, val});
    ->chk;
    #1;
  endtask
  // modeWrite is left high so writes can run back to back
  task automatic wrMode(input logic sel, input logic [1:0] val);
    modeSelect = sel;
    modeValue = val;
    modeWrite = 1;
    step(1);
  endtask
  // fresh random counts each call, they must not disturb steady modes
  task automatic rnd();
    lfsrState = {lfsrState[30:0],
      lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    trackedSats = lfsrState[15:8];
    correctedSats = lfsrState[23:16];
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // monitor: oldest note against the lamps or mode outputs
  always @(chk) begin : mon
    logic [4:0] e;
    logic [1:0] got;
    e = expQ.pop_front();
    case (e[4:2])
      3'h0: got = {1'b0, lit[0]};
      3'h1: got = {1'b0, lit[1]};
      3'h2: got = {1'b0, lit[2]};
      3'h3: got = modeOne_ff;
      default: got = modeTwo_ff;
    endcase
    samplesChecked++;
    if (got !== e[1:0]) begin
      nMismatch++;
      $display("Error at %0t: field %0d got %0h exp %0h", $time, e[4:2],
        got, e[1:0]);
    end
  end
  // hang guard, the whole run needs about 60 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      conclude();
    end
  end
  // ============================================================
  // main sequence
  initial begin
    step(3);
    note(3, `SLEDG_MODE_SOLUTION);
    note(4, `SLEDG_MODE_KINEMATIC);
    note(0, 0);
    rst_n = 1;
    for (int i = 0; i < 8; i++) begin
      rnd();
      solutionValid = lfsrState[0];
      step(3);
      note(0, {1'b0, solutionValid});
    end
    // none, fixed, the unused code, then float in its first lit half
    for (int i = 0; i < 4; i++) begin
      kinematicState = (i == 1) ? `SLEDG_KIN_FIXED :
        (i == 2) ? 2'h3 : (i == 3) ? `SLEDG_KIN_FLOAT : `SLEDG_KIN_NONE;
      step(3);
      note(1, {1'b0, (i == 1) || (i == 3)});
    end
    kinematicState = `SLEDG_KIN_NONE;
    $display("solution and kinematic levels done");
    for (int v = 0; v < 4; v++) begin
      wrMode(0, 2'(v));
      note(3, 2'(v));
    end
    wrMode(1, `SLEDG_MODE_TRACKING);
    note(4, `SLEDG_MODE_TRACKING);
    wrMode(0, `SLEDG_MODE_CORRECTION);
    modeWrite = 0;
    note(3, `SLEDG_MODE_CORRECTION);
    note(4, `SLEDG_MODE_TRACKING);
    baseStation = 1;
    rnd();
    step(3);
    note(0, 1);
    // a burst or fast blink opens lit and stays lit far beyond this run
    note(1, 1);
    baseStation = 0;
    step(3);
    note(0, 0);
    $display("mode writes and correction mode done");
    note(2, 0);
    cardMounted = 1;
    step(3);
    note(2, 1);
    logActivity = 1;
    step(1);
    logActivity = 0;
    step(2);
    note(2, 0);
    rst_n = 0;
    step(1);
    note(4, `SLEDG_MODE_KINEMATIC);
    note(3, `SLEDG_MODE_SOLUTION);
    rst_n = 1;
    step(2);
    $display("logging and mid-run reset done");
    conclude();
  end
endmodule // tb_top
